// ===== common/tcc_pkg.sv
// Package with register map, field positions, encodings and types of the capture counter
package tcc_pkg;
  localparam logic [7:0] ADDR_GLOBAL_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_COMMAND      = 8'h04;
  localparam logic [7:0] ADDR_CTRL         = 8'h08;
  localparam logic [7:0] ADDR_STATUS       = 8'h0C;
  localparam logic [7:0] ADDR_COUNT        = 8'h10;
  localparam logic [7:0] ADDR_CC           = 8'h14;
  localparam logic [7:0] ADDR_CC_BUFF      = 8'h18;
  localparam logic [7:0] ADDR_PERIOD       = 8'h1C;
  localparam logic [7:0] ADDR_TRIG_SRC     = 8'h20;
  localparam logic [7:0] ADDR_TRIG_EDGE    = 8'h24;
  // Control register fields
  localparam int CTRL_SWAP_BIT   = 0;
  localparam int CTRL_PRE_LSB    = 8;
  localparam int CTRL_DIR_LSB    = 16;
  localparam int CTRL_ONESHOT    = 18;
  localparam int CTRL_MODE_LSB   = 24;
  // Command register bits (write one)
  localparam int CMD_CAPTURE     = 0;
  localparam int CMD_RELOAD      = 1;
  localparam int CMD_STOP        = 2;
  localparam int CMD_START       = 3;
  localparam logic [2:0] MODE_TIMER   = 3'h0;
  localparam logic [2:0] MODE_CAPTURE = 3'h2;
  localparam logic [1:0] DIR_UP    = 2'h0;
  localparam logic [1:0] DIR_DOWN  = 2'h1;
  localparam logic [1:0] DIR_UPDN0 = 2'h2;
  localparam logic [1:0] DIR_UPDN1 = 2'h3;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [1:0] EDGE_NONE = 2'h3;
  localparam logic [15:0] PERIOD_RESET  = 16'hFFFF;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] TRIG_SRC_RST  = 32'h0000_0000;
  localparam logic [31:0] TRIG_EDGE_RST = 32'hFFFF_FFFF;
  localparam logic [1:0]  OVUN_HOLD_CYC = 2'h2;
  // Trigger slot order inside the select registers
  localparam int TRG_CAPTURE = 0;
  localparam int TRG_COUNT   = 1;
  localparam int TRG_RELOAD  = 2;
  localparam int TRG_STOP    = 3;
  localparam int TRG_START   = 4;
  localparam int NUM_TRG     = 5;

  typedef struct packed {
    logic [2:0]  mode;
    logic        one_shot;
    logic [1:0]  dir;
    logic [7:0]  prescale;
    logic        swap;
  } tcc_ctrl_t;

  typedef struct packed {
    logic cc;
    logic ov;
    logic un;
    logic tc;
  } tcc_events_t;
endpackage

// ===== core/tcc_counter.sv
// Capture/timer counter with APB register access
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
module tcc_counter #(
  parameter int NUM_TRIG_IN = 16
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [NUM_TRIG_IN-1:0] trig_in,
  output tcc_pkg::tcc_events_t        events,
  output logic                        running
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_HALT = 3'b100
  } tcc_state_t;

  tcc_state_t state;
  tcc_state_t next_state;
  logic        enabled;
  logic [31:0] ctrl_word;
  logic [31:0] trig_src;
  logic [31:0] trig_edge;
  logic [15:0] count;
  logic [15:0] cc_reg;
  logic [15:0] cc_buff;
  logic [15:0] period;
  logic        dir_down;
  logic [7:0]  pre_cnt;
  logic [1:0]  ov_cnt;
  logic [1:0]  un_cnt;
  logic        cc_pulse;
  logic        tc_pulse;
  logic [NUM_TRIG_IN-1:0] trig_q;
  logic [tcc_pkg::NUM_TRG-1:0] trig_ev;
  logic [tcc_pkg::NUM_TRG-1:0] trig_pend;

  tcc_pkg::tcc_ctrl_t ctrl;
  assign ctrl.mode     = ctrl_word[tcc_pkg::CTRL_MODE_LSB +: 3];
  assign ctrl.one_shot = ctrl_word[tcc_pkg::CTRL_ONESHOT];
  assign ctrl.dir      = ctrl_word[tcc_pkg::CTRL_DIR_LSB +: 2];
  assign ctrl.prescale = ctrl_word[tcc_pkg::CTRL_PRE_LSB +: 8];
  assign ctrl.swap     = ctrl_word[tcc_pkg::CTRL_SWAP_BIT];

  // APB decode, zero wait states
  wire wr_en = psel & penable & pwrite;
  wire is_wr_glob  = wr_en & (paddr == tcc_pkg::ADDR_GLOBAL_CTRL);
  wire is_wr_cmd   = wr_en & (paddr == tcc_pkg::ADDR_COMMAND);
  wire is_wr_ctrl  = wr_en & (paddr == tcc_pkg::ADDR_CTRL);
  wire is_wr_count = wr_en & (paddr == tcc_pkg::ADDR_COUNT);
  wire is_wr_cc    = wr_en & (paddr == tcc_pkg::ADDR_CC);
  wire is_wr_ccb   = wr_en & (paddr == tcc_pkg::ADDR_CC_BUFF);
  wire is_wr_per   = wr_en & (paddr == tcc_pkg::ADDR_PERIOD);
  wire is_wr_tsrc  = wr_en & (paddr == tcc_pkg::ADDR_TRIG_SRC);
  wire is_wr_tedge = wr_en & (paddr == tcc_pkg::ADDR_TRIG_EDGE);
  wire addr_hit = (paddr <= tcc_pkg::ADDR_TRIG_EDGE) && (paddr[1:0] == 2'h0);
  wire [3:0] cmd = is_wr_cmd ? pwdata[3:0] : 4'h0;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;

  // Edge detect per trigger slot; source index is 4 bits, edge select 2 bits
  function automatic logic edge_hit(input logic cur, input logic prev, input logic [1:0] sel);
    unique case (sel)
      tcc_pkg::EDGE_RISE: edge_hit = cur & ~prev;
      tcc_pkg::EDGE_FALL: edge_hit = ~cur & prev;
      tcc_pkg::EDGE_BOTH: edge_hit = cur ^ prev;
      tcc_pkg::EDGE_NONE: edge_hit = 1'b0;
    endcase
  endfunction

  genvar g;
  generate
    for (g = 0; g < tcc_pkg::NUM_TRG; g++) begin : g_trig
      wire [3:0] src  = trig_src[g*4 +: 4];
      wire [1:0] esel = trig_edge[g*2 +: 2];
      assign trig_ev[g] = edge_hit(trig_in[src], trig_q[src], esel);
    end
  endgenerate

  // Count clock tick from the prescaler
  wire tick = (pre_cnt == ctrl.prescale);
  // Odd number of capture edges in one count period toggles the pending bit
  wire cap_hw    = trig_pend[tcc_pkg::TRG_CAPTURE];
  wire count_src = (trig_src[tcc_pkg::TRG_COUNT*4 +: 4] == 4'h0) &&
                   (trig_edge[tcc_pkg::TRG_COUNT*2 +: 2] == tcc_pkg::EDGE_NONE);
  wire count_ev  = count_src ? 1'b1 : trig_pend[tcc_pkg::TRG_COUNT];
  wire is_timer  = (ctrl.mode == tcc_pkg::MODE_TIMER);
  wire is_cap    = (ctrl.mode == tcc_pkg::MODE_CAPTURE);
  wire mode_ok   = is_timer | is_cap;
  wire cnt_tick  = tick & (state == ST_RUN) & count_ev & mode_ok;
  wire updown    = ctrl.dir[1];

  wire start_req  = cmd[tcc_pkg::CMD_START] |
                    (trig_ev[tcc_pkg::TRG_START] & enabled);
  wire stop_req   = cmd[tcc_pkg::CMD_STOP] | trig_ev[tcc_pkg::TRG_STOP];
  wire reload_req = cmd[tcc_pkg::CMD_RELOAD] | trig_ev[tcc_pkg::TRG_RELOAD];
  wire cap_req    = is_cap & (state == ST_RUN) &
                    ((tick & cap_hw) | cmd[tcc_pkg::CMD_CAPTURE]);

  // End-point detection
  wire at_top  = (count == period);
  wire at_zero = (count == 16'h0000);
  wire going_down = updown ? dir_down : (ctrl.dir == tcc_pkg::DIR_DOWN);
  wire hit_ov = cnt_tick & ~going_down & at_top;
  wire hit_un = cnt_tick & going_down & at_zero;
  logic tc_now;
  always_comb begin
    unique case (ctrl.dir)
      tcc_pkg::DIR_UP:    tc_now = hit_ov;
      tcc_pkg::DIR_DOWN:  tc_now = hit_un;
      tcc_pkg::DIR_UPDN0: tc_now = hit_un;
      tcc_pkg::DIR_UPDN1: tc_now = hit_un | hit_ov;
    endcase
  end
  // Capture mode also flags at the period value regardless of direction
  wire ov_now = hit_ov | (is_cap & cnt_tick & at_top & going_down);

  logic [15:0] next_count;
  always_comb begin
    next_count = count;
    if (reload_req) begin
      next_count = (ctrl.dir == tcc_pkg::DIR_DOWN) ? period : 16'h0000;
    end else if (cnt_tick) begin
      if (updown) begin
        // No reload at the ends, only turn around                              // 
        if (~dir_down & at_top)
          next_count = count - 16'h0001;
        else if (dir_down & at_zero)
          next_count = count + 16'h0001;
        else
          next_count = dir_down ? count - 16'h0001 : count + 16'h0001;
      end else if (ctrl.dir == tcc_pkg::DIR_DOWN) begin
        next_count = at_zero ? period : count - 16'h0001;
      end else begin
        next_count = at_top ? 16'h0000 : count + 16'h0001;
      end
    end
  end

  logic next_dir_down;
  always_comb begin
    next_dir_down = dir_down;
    if (reload_req)
      next_dir_down = 1'b0;
    else if (cnt_tick & updown & ~dir_down & at_top)
      next_dir_down = 1'b1;
    else if (cnt_tick & updown & dir_down & at_zero)
      next_dir_down = 1'b0;
  end

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (start_req & enabled) next_state = ST_RUN;
      ST_RUN: begin
        if (~enabled | stop_req)
          next_state = ST_IDLE;
        else if (ctrl.one_shot & tc_now)
          next_state = ST_HALT;
      end
      ST_HALT: begin
        if (~enabled) next_state = ST_IDLE;
        else if (start_req) next_state = ST_RUN;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  wire cmp_hit = is_timer & cnt_tick & (count == cc_reg);

  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enabled   <= 1'b0;
      ctrl_word <= tcc_pkg::CTRL_RESET;
      trig_src  <= tcc_pkg::TRIG_SRC_RST;
      trig_edge <= tcc_pkg::TRIG_EDGE_RST;
      period    <= tcc_pkg::PERIOD_RESET;
    end else begin
      if (is_wr_glob)  enabled   <= pwdata[0];
      if (is_wr_ctrl)  ctrl_word <= pwdata;
      if (is_wr_tsrc)  trig_src  <= pwdata;
      if (is_wr_tedge) trig_edge <= pwdata;
      if (is_wr_per)   period    <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cc_reg  <= 16'h0000;
      cc_buff <= 16'h0000;
    end else if (cap_req) begin
      cc_buff <= cc_reg;
      cc_reg  <= count;
    end else if (cmp_hit & ctrl.swap) begin
      cc_reg  <= cc_buff;
      cc_buff <= cc_reg;
    end else begin
      if (is_wr_cc)  cc_reg  <= pwdata[15:0];
      if (is_wr_ccb) cc_buff <= pwdata[15:0];
    end
  end

  // Writing the count while running is allowed; the write replaces that cycle's count step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count    <= 16'h0000;
      dir_down <= 1'b0;
      state    <= ST_IDLE;
    end else begin
      count    <= is_wr_count ? pwdata[15:0] : next_count;
      dir_down <= next_dir_down;
      state    <= next_state;
    end
  end

  // Prescaler restarts when stopped so the first count comes a full period later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pre_cnt <= 8'h00;
    else if (state != ST_RUN | tick)
      pre_cnt <= 8'h00;
    else
      pre_cnt <= pre_cnt + 8'h01;
  end

  // Trigger edges between ticks: parity kept so paired edges cancel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_q    <= '0;
      trig_pend <= '0;
    end else begin
      trig_q <= trig_in;
      for (int i = 0; i < tcc_pkg::NUM_TRG; i++) begin
        if (tick)
          trig_pend[i] <= trig_ev[i];
        else
          trig_pend[i] <= trig_pend[i] ^ trig_ev[i];
      end
    end
  end

  // Overflow and underflow stretched to two system clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_cnt   <= 2'h0;
      un_cnt   <= 2'h0;
      cc_pulse <= 1'b0;
      tc_pulse <= 1'b0;
    end else begin
      ov_cnt   <= ov_now ? tcc_pkg::OVUN_HOLD_CYC :
                  (ov_cnt != 2'h0) ? ov_cnt - 2'h1 : 2'h0;
      un_cnt   <= hit_un ? tcc_pkg::OVUN_HOLD_CYC :
                  (un_cnt != 2'h0) ? un_cnt - 2'h1 : 2'h0;
      cc_pulse <= cmp_hit | cap_req;
      tc_pulse <= tc_now | (is_cap & ov_now);
    end
  end

  assign events.cc = cc_pulse;
  assign events.ov = (ov_cnt != 2'h0);
  assign events.un = (un_cnt != 2'h0);
  assign events.tc = tc_pulse;
  assign running   = (state == ST_RUN);

  // Read mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      tcc_pkg::ADDR_GLOBAL_CTRL: rd_mux = {31'h0, enabled};
      tcc_pkg::ADDR_CTRL:        rd_mux = ctrl_word;
      tcc_pkg::ADDR_STATUS:      rd_mux = {29'h0, state == ST_HALT, dir_down,
                                           state == ST_RUN};
      tcc_pkg::ADDR_COUNT:       rd_mux = {16'h0, count};
      tcc_pkg::ADDR_CC:          rd_mux = {16'h0, cc_reg};
      tcc_pkg::ADDR_CC_BUFF:     rd_mux = {16'h0, cc_buff};
      tcc_pkg::ADDR_PERIOD:      rd_mux = {16'h0, period};
      tcc_pkg::ADDR_TRIG_SRC:    rd_mux = trig_src;
      tcc_pkg::ADDR_TRIG_EDGE:   rd_mux = trig_edge;
      default:                   rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite)
      prdata <= rd_mux;
  end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the capture counter
`timescale 1ns/1ps
module tb;
  localparam int NUM_TRIG_IN = 16;
  logic                   pclk    = 1'b0;
  logic                   presetn = 1'b0;
  logic                   psel    = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite  = 1'b0;
  logic [7:0]             paddr   = 8'h00;
  logic [31:0]            pwdata  = 32'h0000_0000;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic [NUM_TRIG_IN-1:0] trig_in;
  tcc_pkg::tcc_events_t   events;
  logic                   running;
  logic [31:0]            rd;
  logic                   err;
  logic                   hit;
  logic [31:0]            n;
  logic [31:0]            c1;
  int                     fails = 0;
  int                     comparisons = 0;
  logic [31:0]            gap_exp [4] = '{32'h4, 32'h4, 32'h6, 32'h3};
  // Overflow in bit 1, underflow in bit 0, seen with the terminal count
  logic [31:0]            end_exp [3] = '{32'h2, 32'h1, 32'h1};
  always #2.5 pclk = ~pclk;
  tcc_counter #(.NUM_TRIG_IN(NUM_TRIG_IN)) tcc_counter_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trig_in(trig_in), .events(events), .running(running));
  tcc_trig_model tcc_trig_model_inst (.pclk(pclk), .trig(trig_in));
  task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Edge counts are judged one clock late, so a limit is never exact
  task automatic wait_ev(input logic sel, input int lim);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((sel ? events.cc : events.tc) !== 1'b1 && n < lim);
    hit = sel ? events.cc : events.tc;
  endtask
  task automatic cfg(input logic [31:0] c, p, v, b, e);
    apb(1'b1, tcc_pkg::ADDR_GLOBAL_CTRL, 32'h0);
    apb(1'b1, tcc_pkg::ADDR_CTRL, c);
    apb(1'b1, tcc_pkg::ADDR_PERIOD, p);
    apb(1'b1, tcc_pkg::ADDR_CC, v);
    apb(1'b1, tcc_pkg::ADDR_CC_BUFF, b);
    apb(1'b1, tcc_pkg::ADDR_TRIG_EDGE, e);
    apb(1'b1, tcc_pkg::ADDR_COUNT, 32'h0);
    apb(1'b1, tcc_pkg::ADDR_GLOBAL_CTRL, 32'h1);
    repeat (4) @(posedge pclk);
    cmp_word("running before start", 32'h0, {31'h0, running});
    apb(1'b1, tcc_pkg::ADDR_COMMAND, 32'h1 << tcc_pkg::CMD_START);
  endtask
  task automatic t_regs;
    apb(1'b0, tcc_pkg::ADDR_PERIOD, 32'h0);
    cmp_word("period reset", 32'h0000_FFFF, rd);
    apb(1'b0, tcc_pkg::ADDR_TRIG_EDGE, 32'h0);
    cmp_word("edge select reset", 32'hFFFF_FFFF, rd);
    apb(1'b0, tcc_pkg::ADDR_CTRL, 32'h0);
    cmp_word("control reset", 32'h0, rd);
    apb(1'b1, tcc_pkg::ADDR_PERIOD, 32'h0001_2345);
    apb(1'b0, tcc_pkg::ADDR_PERIOD, 32'h0);
    cmp_word("period width", 32'h0000_2345, rd);
    apb(1'b0, 8'h28, 32'h0);
    cmp_word("unmapped error", 32'h1, {31'h0, err});
    cmp_word("unmapped data", 32'h0, rd);
    $display("test regs done");
  endtask
  task automatic t_dirs;
    for (int d = 0; d < 4; d++) begin
      cfg(32'(d) << 16, 32'h3, 32'h0, 32'h0, 32'hFFFF_FFFF);
      wait_ev(1'b0, 2000);
      wait_ev(1'b0, 2000);
      cmp_word("terminal count gap", gap_exp[d], n);
      if (d < 3) begin
        cmp_word("end flags", end_exp[d], {30'h0, events.ov, events.un});
      end
    end
    cfg(32'h0000_0100, 32'h3, 32'h0, 32'h0, 32'hFFFF_FFFF);
    wait_ev(1'b0, 2000);
    wait_ev(1'b0, 2000);
    cmp_word("prescaled gap", 32'h8, n);
    $display("test directions done");
  endtask
  task automatic t_modes;
    cfg(32'h0100_0000, 32'h3, 32'h0, 32'h0, 32'hFFFF_FFFF);
    wait_ev(1'b0, 100);
    cmp_word("idle mode count", 32'h0, {31'h0, hit});
    cfg(32'h0004_0000, 32'h2, 32'h0, 32'h0, 32'hFFFF_FFFF);
    wait_ev(1'b0, 100);
    cmp_word("one-shot end", 32'h1, {31'h0, hit});
    wait_ev(1'b0, 60);
    cmp_word("one-shot halt", 32'h0, {31'h0, hit});
    cmp_word("one-shot stopped", 32'h0, {31'h0, running});
    $display("test modes done");
  endtask
  task automatic t_compare;
    cfg(32'h0000_0F01, 32'h7, 32'h2, 32'h5, 32'hFFFF_FFFF);
    wait_ev(1'b1, 400);
    cmp_word("compare event", 32'h1, {31'h0, hit});
    apb(1'b0, tcc_pkg::ADDR_CC, 32'h0);
    cmp_word("swapped compare", 32'h5, rd);
    apb(1'b0, tcc_pkg::ADDR_CC_BUFF, 32'h0);
    cmp_word("swapped buffer", 32'h2, rd);
    apb(1'b1, tcc_pkg::ADDR_COMMAND, 32'h1 << tcc_pkg::CMD_STOP);
    @(posedge pclk);
    cmp_word("stopped by command", 32'h0, {31'h0, running});
    apb(1'b1, tcc_pkg::ADDR_COMMAND, 32'h1 << tcc_pkg::CMD_RELOAD);
    apb(1'b0, tcc_pkg::ADDR_COUNT, 32'h0);
    cmp_word("reloaded count", 32'h0, rd);
    $display("test compare done");
  endtask
  // Software never writes the count while running
  task automatic t_capture;
    cfg(32'h0200_FF00, 32'hFFFF, 32'h0, 32'h0, 32'hFFFF_FFFC);
    tcc_trig_model_inst.pulses(1);
    wait_ev(1'b1, 300);
    cmp_word("single edge capture", 32'h1, {31'h0, hit});
    tcc_trig_model_inst.pulses(2);
    wait_ev(1'b1, 300);
    cmp_word("even edges capture", 32'h0, {31'h0, hit});
    apb(1'b1, tcc_pkg::ADDR_COMMAND, 32'h1 << tcc_pkg::CMD_CAPTURE);
    wait_ev(1'b1, 300);
    cmp_word("software capture", 32'h1, {31'h0, hit});
    apb(1'b0, tcc_pkg::ADDR_CC, 32'h0);
    c1 = rd;
    apb(1'b1, tcc_pkg::ADDR_COMMAND, 32'h1 << tcc_pkg::CMD_CAPTURE);
    wait_ev(1'b1, 300);
    apb(1'b0, tcc_pkg::ADDR_CC_BUFF, 32'h0);
    cmp_word("capture shifted to buffer", c1, rd);
    cfg(32'h0200_0000, 32'h3, 32'h0, 32'h0, 32'hFFFF_FFFF);
    wait_ev(1'b0, 100);
    wait_ev(1'b0, 100);
    cmp_word("capture mode period gap", 32'h4, n);
    cmp_word("capture mode overflow", 32'h2, {30'h0, events.ov, events.un});
    $display("test capture done");
  endtask
  task automatic complete_run;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_dirs();
    t_modes();
    t_compare();
    t_capture();
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge pclk);
    fails++;
    complete_run();
  end
endmodule
bind tcc_counter tcc_counter_asserts #(.NUM_TRIG_IN(NUM_TRIG_IN)) tcc_counter_asserts_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .trig_in(trig_in), .events(events), .running(running));

// ===== tb/tcc_counter_asserts.sv
// Port-level checks bound onto the capture counter
`timescale 1ns/1ps
module tcc_counter_asserts #(
  parameter int NUM_TRIG_IN = 16
) (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [7:0]             paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic [NUM_TRIG_IN-1:0] trig_in,
  input wire tcc_pkg::tcc_events_t   events,
  input wire logic                   running
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire start_wr = psel && penable && pwrite && paddr == tcc_pkg::ADDR_COMMAND
                  && pwdata[tcc_pkg::CMD_START];
  wire bad_addr = paddr > tcc_pkg::ADDR_TRIG_EDGE || paddr[1:0] != 2'h0;
  sequence s_hold2(logic s);
    s ##1 s ##1 !s;
  endsequence
  chk_ov_two_cycles: assert property ($rose(events.ov) |-> s_hold2(events.ov))
    else $error("overflow not high for two cycles");
  chk_un_two_cycles: assert property ($rose(events.un) |-> s_hold2(events.un))
    else $error("underflow not high for two cycles");
  chk_start_by_cmd: assert property ($rose(running) |-> $past(start_wr))
    else $error("counter started without a start command");
  chk_tc_at_end: assert property (events.tc |-> $rose(events.ov) || $rose(events.un))
    else $error("terminal count away from an end value");
  chk_event_running: assert property (events.tc || events.cc |-> $past(running))
    else $error("event raised while stopped");
  chk_tc_single: assert property (events.tc |=> !events.tc)
    else $error("terminal count longer than one cycle");
  chk_ends_apart: assert property (!(events.ov && events.un))
    else $error("overflow and underflow together");
  chk_err_map: assert property (psel && penable |-> pslverr == bad_addr)
    else $error("error response does not match address");
endmodule

// ===== tb/tcc_trig_model.sv
// Trigger line source standing in for the on-chip trigger fabric
`timescale 1ns/1ps
module tcc_trig_model (
  input  wire logic        pclk,
  output logic      [15:0] trig
);
  initial trig = 16'h0000;
  // Pulses stay two clocks wide so the edge detector cannot miss them
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      trig[0] <= 1'b1;
      repeat (2) @(posedge pclk);
      trig[0] <= 1'b0;
      @(posedge pclk);
    end
  endtask
endmodule
